/* src/tsba_pkg.sv */
/*
 Shared constants and carrier types for the touch setups block and alert logic.
 Assumes a 250 MHz system clock and a byte-wide host stream from the serial front end.
*/
package tsba_pkg;
    // ==========================================================
    // Block layout
    localparam int unsigned BLOCK_LEN = 247;
    localparam logic [7:0] BLOCK_LAST = 8'hF6;
    localparam logic [5:0] NUM_KEYS = 6'h30;
    localparam logic [5:0] LAST_KEY = 6'h2F;
    localparam logic [7:0] OFS_THR = 8'h00;
    localparam logic [7:0] OFS_DRIFT = 8'h30;
    localparam logic [7:0] OFS_DIL = 8'h60;
    localparam logic [7:0] OFS_NRD = 8'h90;
    localparam logic [7:0] OFS_OPT = 8'hC0;
    localparam logic [7:0] OFS_GLOB = 8'hF0;
    localparam logic [7:0] OFS_SPACE = 8'hF1;
    localparam logic [7:0] OFS_LSL = 8'hF2;
    localparam logic [7:0] OFS_ALERT = 8'hF4;
    localparam logic [7:0] OFS_CRC = 8'hF5;
    localparam logic [7:0] CMD_SETUPS = 8'h01;
    localparam logic [4:0] THR_ADD = 5'h04;
    // ==========================================================
    // Reset values of the setups bytes
    localparam logic [7:0] DEF_THR = 8'h26;
    localparam logic [7:0] DEF_DRIFT = 8'h4A;
    localparam logic [7:0] DEF_DIL = 8'h52;
    localparam logic [7:0] DEF_NRD = 8'h14;
    localparam logic [7:0] DEF_OPT = 8'h26;
    localparam logic [7:0] DEF_GLOB = 8'h01;
    localparam logic [7:0] DEF_SPACE = 8'h00;
    localparam logic [7:0] DEF_LSL_LO = 8'h64;
    localparam logic [7:0] DEF_ALERT = 8'h6C;
    // ==========================================================
    // Alert function bit positions
    localparam int AL_POL = 7;
    localparam int AL_KEYERR = 6;
    localparam int AL_PRESS = 5;
    localparam int AL_SLEEP = 4;
    localparam int AL_EEP = 3;
    localparam int AL_MAINS = 2;
    localparam int AL_COMMS = 1;
    localparam int AL_WDOG = 0;
    // ==========================================================
    // Timing
    localparam int unsigned CLK_HZ = 250_000_000;
    localparam int unsigned WDOG_MS = 2000;
    localparam int unsigned PULSE_MS = 150;
    localparam int unsigned SLOT_BASE_US = 500;
    localparam int unsigned SLOT_STEP_US = 250;
    localparam int unsigned WDOG_CYC = CLK_HZ / 1000 * WDOG_MS;
    localparam int unsigned PULSE_CYC = CLK_HZ / 1000 * PULSE_MS;
    localparam int unsigned SLOT_BASE_CYC = CLK_HZ / 1_000_000 * SLOT_BASE_US;
    localparam int unsigned SLOT_STEP_CYC = CLK_HZ / 1_000_000 * SLOT_STEP_US;
    localparam logic [3:0] BS_MAX = 4'hB;
    localparam logic [3:0] SR_MAX = 4'h4;
    localparam logic [15:0] BAUD0_DIV = 16'(CLK_HZ / 9600);
    localparam logic [15:0] BAUD1_DIV = 16'(CLK_HZ / 19200);
    localparam logic [15:0] BAUD2_DIV = 16'(CLK_HZ / 38400);
    localparam logic [15:0] BAUD3_DIV = 16'(CLK_HZ / 57600);
    localparam logic [15:0] BAUD4_DIV = 16'(CLK_HZ / 115200);
    // ==========================================================
    // Carriers
    typedef struct packed {
        logic [4:0] neg_threshold;
        logic [4:0] pos_threshold;
        logic [3:0] neg_drift_rate;
        logic [3:0] pos_drift_rate;
        logic [3:0] normal_detect_count;
        logic [3:0] fast_detect_count;
        logic burst_en;
        logic fast_valid;
        logic [7:0] neg_recal_delay;
        logic [3:0] pos_recal_delay;
        logic [1:0] burst_length_code;
        logic strongest_key_only;
        logic scope_trigger_enable;
    } tsba_key_t;
    typedef struct packed {
        logic [3:0] release_margin;
        logic [1:0] dwell_code;
        logic mains_lock_enable;
        logic [3:0] burst_slot_time;
        logic [3:0] uart_baud_select;
        logic [15:0] minimum_reference_level;
        logic [7:0] alert_function;
        logic [15:0] setup_block_checksum;
    } tsba_glob_t;
    typedef struct packed {
        logic key_fault;
        logic key_press;
        logic sleep;
        logic eeprom_err;
        logic mains_err;
    } tsba_cond_t;

    // Byte address of a per-key field
    function automatic logic [7:0] tsba_kidx(input logic [7:0] ofs, input logic [5:0] k);
        return ofs + {2'h0, k};
    endfunction
endpackage

/* src/tsba_burst_slot.sv */
/*
 Burst timeslot scheduler: one start pulse per slot, keys taken in turn.
 Assumes burst_busy comes from acquisition logic on the same clock.
*/
`timescale 1ns/100ps
module tsba_burst_slot import tsba_pkg::*; #(
    parameter int unsigned SLOT_BASE = SLOT_BASE_CYC,
    parameter int unsigned SLOT_STEP = SLOT_STEP_CYC
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic sys_rst,
    // Setting and acquisition feedback
    input wire logic [3:0] slot_code,
    input wire logic burst_busy,
    // Schedule
    output logic burst_start_q,
    output logic [5:0] burst_key_q
);
    logic [31:0] tmr_q;
    logic [31:0] meas_q;
    logic [31:0] fit_q;
    logic fit_done_q;
    logic seen_q;
    logic [31:0] slot_len;

    // ==========================================================
    // Slot length; codes above the range fall back to the longest
    always_comb begin
        if (slot_code == 4'h0) begin
            slot_len = fit_done_q ? fit_q : SLOT_BASE;
        end else if (slot_code > BS_MAX) begin
            slot_len = SLOT_BASE + 32'(BS_MAX - 4'h1) * SLOT_STEP;
        end else begin
            slot_len = SLOT_BASE + 32'(slot_code - 4'h1) * SLOT_STEP;
        end
    end

    // Same start-to-start interval for every key
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            tmr_q <= 32'h0;
            burst_start_q <= 1'b0;
            burst_key_q <= 6'h0;
        end else begin
            burst_start_q <= 1'b0;
            if (tmr_q + 32'h1 >= slot_len) begin
                tmr_q <= 32'h0;
                burst_start_q <= 1'b1;
                burst_key_q <= (burst_key_q == LAST_KEY) ? 6'h0 : burst_key_q + 6'h1;
            end else begin
                tmr_q <= tmr_q + 32'h1;
            end
        end
    end

    // Fit once after reset from the first burst, then frozen
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            meas_q <= 32'h0;
            fit_q <= 32'h0;
            fit_done_q <= 1'b0;
            seen_q <= 1'b0;
        end else if (!fit_done_q) begin
            if (burst_busy) begin
                seen_q <= 1'b1;
                meas_q <= meas_q + 32'h1;
            end else if (seen_q) begin
                fit_q <= (meas_q > SLOT_BASE) ? meas_q : SLOT_BASE;
                fit_done_q <= 1'b1;
            end
        end
    end

    fit_frozen_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        fit_done_q |=> fit_done_q && $stable(fit_q)) else $error("auto slot fit changed");
    slot_spacing_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        burst_start_q |=> !burst_start_q) else $error("burst starts back to back");
endmodule // tsba_burst_slot

/* src/tsba_setup_alert.sv */
/*
 Setups block store with host loader, parameter readout, reference check and alert pin.
 Assumes host bytes and condition inputs come from logic on clk_sys.
*/
// Function
// - Each key's burst starts in a scheduled slot; one spacing for all keys.
// - Spacing code 0 is automatic, 1 to 11 give 500us to 3ms.
// - Automatic spacing is fitted once after reset and held until reset.
// - Baud selection touches only the UART; SPI rate is independent.
// - Baud codes 0 to 4 give 9600 to 115.2K; default 9600.
// - Reference below the lower signal limit flags an error for that key.
// - Alert is active when any enabled condition is true, ORed together.
// - Alert polarity selectable; alert function byte defaults to 0x6C.
// - Watchdog pulses alert after 2s host silence, armed by first command.
// - Alert level is held throughout sleep unless the sleep condition is enabled.
// - The 247-byte block loads only after two consecutive 0x01 commands.
// - Threshold byte: negative low nibble, positive high; value is code plus 4.
// - Drift bytes from 48: negative low nibble, positive high nibble.
// - Detect-count bytes from 96: normal low (0 disables), fast high.
// - Negative recalibration delay in 0.5s steps; 0 means never; 255 illegal.
// - Bytes from 192: recal delay, burst length 5:4, suppression 6, scope 7.
// - Byte 240: release margin, dwell code 5:4, mains lock bit 6.
// - Byte 241: burst spacing low nibble, baud code high nibble.
// - Alert byte: bit 7 polarity, bits 6..1 condition enables, bit 0 watchdog.
// - Watchdog reset pulse on the alert pin lasts 150ms.
// - Comms error holds alert active until get-last-command or reset.
`timescale 1ns/100ps
module tsba_setup_alert import tsba_pkg::*; #(
    parameter int unsigned WDOG_CYCLES = WDOG_CYC,
    parameter int unsigned PULSE_CYCLES = PULSE_CYC,
    parameter int unsigned SLOT_BASE = SLOT_BASE_CYC,
    parameter int unsigned SLOT_STEP = SLOT_STEP_CYC
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic sys_rst,
    // Host byte stream and command events
    input wire logic host_valid,
    input wire logic [7:0] host_byte,
    input wire logic cmd_unknown,
    input wire logic cmd_get_last,
    // Key parameter readout
    input wire logic [5:0] key_sel,
    output tsba_key_t key_param_q,
    // Global settings
    output tsba_glob_t glob_q,
    output logic setups_mode_q,
    output logic block_loaded_q,
    output logic [15:0] uart_baud_div_q,
    // Reference level check
    input wire logic ref_valid,
    input wire logic [5:0] ref_key,
    input wire logic [15:0] ref_level,
    output logic [47:0] key_low_sig_q,
    // Alert conditions and pin
    input wire tsba_cond_t cond,
    output logic alert_out_q,
    // Burst schedule
    input wire logic burst_busy,
    output logic burst_start_q,
    output logic [5:0] burst_key_q
);
    typedef enum logic [1:0] {TSBA_IDLE, TSBA_ONE, TSBA_LOAD} tsba_state_t;

    tsba_state_t state_q;
    logic [7:0] setup_q [BLOCK_LEN];
    logic [7:0] wr_idx_q;
    logic comms_err_q;
    logic armed_q;
    logic [31:0] quiet_q;
    logic [31:0] pulse_q;
    logic wd_fire;
    logic pulse_act;
    logic alert_act;
    logic [7:0] alert_fn;
    logic [15:0] min_ref;
    logic [7:0] thr_byte;
    logic [7:0] opt_byte;

    // ==========================================================
    // Setups mode entry and block loading
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            state_q <= TSBA_IDLE;
            wr_idx_q <= 8'h0;
            block_loaded_q <= 1'b0;
        end else if (host_valid) begin
            case (state_q)
                TSBA_IDLE: begin
                    if (host_byte == CMD_SETUPS) begin
                        state_q <= TSBA_ONE;
                    end
                end
                TSBA_ONE: begin
                    // Any other byte breaks the pair
                    state_q <= (host_byte == CMD_SETUPS) ? TSBA_LOAD : TSBA_IDLE;
                    wr_idx_q <= 8'h0;
                end
                TSBA_LOAD: begin
                    wr_idx_q <= wr_idx_q + 8'h1;
                    if (wr_idx_q == BLOCK_LAST) begin
                        state_q <= TSBA_IDLE;
                        block_loaded_q <= 1'b1;
                    end
                end
                default: begin
                    state_q <= TSBA_IDLE;
                end
            endcase
        end
    end

    // Byte store; only written in setups mode, checksum kept as sent
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            for (int i = 0; i < BLOCK_LEN; i++) begin
                if (i < int'(OFS_DRIFT)) begin
                    setup_q[i] <= DEF_THR;
                end else if (i < int'(OFS_DIL)) begin
                    setup_q[i] <= DEF_DRIFT;
                end else if (i < int'(OFS_NRD)) begin
                    setup_q[i] <= DEF_DIL;
                end else if (i < int'(OFS_OPT)) begin
                    setup_q[i] <= DEF_NRD;
                end else if (i < int'(OFS_GLOB)) begin
                    setup_q[i] <= DEF_OPT;
                end else begin
                    setup_q[i] <= 8'h00;
                end
            end
            setup_q[OFS_GLOB] <= DEF_GLOB;
            setup_q[OFS_SPACE] <= DEF_SPACE;
            setup_q[OFS_LSL] <= DEF_LSL_LO;
            setup_q[OFS_ALERT] <= DEF_ALERT;
        end else if (host_valid && state_q == TSBA_LOAD) begin
            setup_q[wr_idx_q] <= host_byte;
        end
    end

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            setups_mode_q <= 1'b0;
        end else begin
            setups_mode_q <= (state_q == TSBA_LOAD) && !(host_valid && wr_idx_q == BLOCK_LAST);
            if (state_q == TSBA_ONE && host_valid && host_byte == CMD_SETUPS) begin
                setups_mode_q <= 1'b1;
            end
        end
    end

    // ==========================================================
    // Per-key field decode
    assign thr_byte = setup_q[tsba_kidx(OFS_THR, key_sel)];
    assign opt_byte = setup_q[tsba_kidx(OFS_OPT, key_sel)];

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            key_param_q <= '0;
        end else if (key_sel < NUM_KEYS) begin
            key_param_q.neg_threshold <= {1'b0, thr_byte[3:0]} + THR_ADD;
            key_param_q.pos_threshold <= {1'b0, thr_byte[7:4]} + THR_ADD;
            key_param_q.neg_drift_rate <= setup_q[tsba_kidx(OFS_DRIFT, key_sel)][3:0];
            key_param_q.pos_drift_rate <= setup_q[tsba_kidx(OFS_DRIFT, key_sel)][7:4];
            key_param_q.normal_detect_count <= setup_q[tsba_kidx(OFS_DIL, key_sel)][3:0];
            key_param_q.fast_detect_count <= setup_q[tsba_kidx(OFS_DIL, key_sel)][7:4];
            key_param_q.burst_en <= |setup_q[tsba_kidx(OFS_DIL, key_sel)][3:0];
            key_param_q.fast_valid <= |setup_q[tsba_kidx(OFS_DIL, key_sel)][7:4];
            key_param_q.neg_recal_delay <= setup_q[tsba_kidx(OFS_NRD, key_sel)];
            key_param_q.pos_recal_delay <= opt_byte[3:0];
            key_param_q.burst_length_code <= opt_byte[5:4];
            key_param_q.strongest_key_only <= opt_byte[6];
            key_param_q.scope_trigger_enable <= opt_byte[7];
        end
    end

    // ==========================================================
    // Global fields
    assign alert_fn = setup_q[OFS_ALERT];
    assign min_ref = {setup_q[OFS_LSL + 8'h1], setup_q[OFS_LSL]};

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            glob_q <= '0;
        end else begin
            glob_q.release_margin <= setup_q[OFS_GLOB][3:0];
            glob_q.dwell_code <= setup_q[OFS_GLOB][5:4];
            glob_q.mains_lock_enable <= setup_q[OFS_GLOB][6];
            glob_q.burst_slot_time <= setup_q[OFS_SPACE][3:0];
            glob_q.uart_baud_select <= setup_q[OFS_SPACE][7:4];
            glob_q.minimum_reference_level <= min_ref;
            glob_q.alert_function <= alert_fn;
            glob_q.setup_block_checksum <= {setup_q[OFS_CRC + 8'h1], setup_q[OFS_CRC]};
        end
    end

    // UART divider only; SPI clocking never looks at it. Bad codes keep 9600.
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            uart_baud_div_q <= BAUD0_DIV;
        end else begin
            case (setup_q[OFS_SPACE][7:4])
                4'h1: uart_baud_div_q <= BAUD1_DIV;
                4'h2: uart_baud_div_q <= BAUD2_DIV;
                4'h3: uart_baud_div_q <= BAUD3_DIV;
                4'h4: uart_baud_div_q <= BAUD4_DIV;
                default: uart_baud_div_q <= BAUD0_DIV;
            endcase
        end
    end

    // ==========================================================
    // Reference level check; flag tracks the latest sample of each key
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            key_low_sig_q <= 48'h0;
        end else if (ref_valid && ref_key < NUM_KEYS) begin
            key_low_sig_q[ref_key] <= (ref_level < min_ref);
        end
    end

    // ==========================================================
    // Comms error latch; a new error wins over a same-cycle clear
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            comms_err_q <= 1'b0;
        end else begin
            comms_err_q <= cmd_unknown | (comms_err_q & ~cmd_get_last);
        end
    end

    // Host watchdog: silent until the first host byte arrives
    assign wd_fire = armed_q && alert_fn[AL_WDOG] && quiet_q + 32'h1 >= WDOG_CYCLES && !host_valid;
    assign pulse_act = (pulse_q != 32'h0);

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            armed_q <= 1'b0;
            quiet_q <= 32'h0;
            pulse_q <= 32'h0;
        end else begin
            if (host_valid) begin
                armed_q <= 1'b1;
            end
            if (host_valid || !alert_fn[AL_WDOG] || wd_fire) begin
                quiet_q <= 32'h0;
            end else if (armed_q) begin
                quiet_q <= quiet_q + 32'h1;
            end
            if (wd_fire) begin
                pulse_q <= PULSE_CYCLES;
            end else if (pulse_act) begin
                pulse_q <= pulse_q - 32'h1;
            end
        end
    end

    // ==========================================================
    // Alert pin: OR of enabled conditions, then polarity
    assign alert_act = (alert_fn[AL_KEYERR] & ((|key_low_sig_q) | cond.key_fault))
        | (alert_fn[AL_PRESS] & cond.key_press)
        | (alert_fn[AL_SLEEP] & cond.sleep)
        | (alert_fn[AL_EEP] & cond.eeprom_err)
        | (alert_fn[AL_MAINS] & cond.mains_err)
        | (alert_fn[AL_COMMS] & comms_err_q)
        | pulse_act;

    // Frozen in sleep unless the sleep term is enabled to drive it
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            alert_out_q <= ~DEF_ALERT[AL_POL];
        end else if (!cond.sleep || alert_fn[AL_SLEEP]) begin
            alert_out_q <= alert_fn[AL_POL] ? alert_act : ~alert_act;
        end
    end

    // ==========================================================
    // Burst slot scheduling
    tsba_burst_slot #(
        .SLOT_BASE(SLOT_BASE),
        .SLOT_STEP(SLOT_STEP)
    ) u_slot (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .slot_code(setup_q[OFS_SPACE][3:0]),
        .burst_busy(burst_busy),
        .burst_start_q(burst_start_q),
        .burst_key_q(burst_key_q)
    );

    // ==========================================================
    // Checks
    // Commands one idle cycle apart; other gaps are left to the bench
    sequence s_pair;
        host_valid && host_byte == CMD_SETUPS ##1 !host_valid ##1 host_valid && host_byte == CMD_SETUPS;
    endsequence
    sequence s_idle_pair;
        state_q == TSBA_IDLE ##0 s_pair;
    endsequence

    setups_entry_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        s_idle_pair |=> setups_mode_q) else $error("setups mode not entered");
    store_guard_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        !$stable(setup_q[OFS_ALERT]) |-> $past(state_q == TSBA_LOAD && host_valid))
        else $error("store written outside setups mode");
    thr_decode_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        !sys_rst && key_sel < NUM_KEYS |=> key_param_q.neg_threshold == {1'b0, $past(thr_byte[3:0])} + 5'h04)
        else $error("threshold offset wrong");
    low_sig_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        ref_valid && ref_key < NUM_KEYS && ref_level < min_ref |=> key_low_sig_q[$past(ref_key)])
        else $error("low reference not flagged");
    alert_or_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        !cond.sleep && alert_act |=> alert_out_q == $past(alert_fn[AL_POL]))
        else $error("alert not active for enabled condition");
    comms_hold_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        comms_err_q && !cmd_get_last |=> comms_err_q) else $error("comms error dropped early");
    sleep_hold_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        cond.sleep && !alert_fn[AL_SLEEP] |=> $stable(alert_out_q)) else $error("alert moved in sleep");
    wdog_arm_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        !armed_q |-> !wd_fire && !pulse_act) else $error("watchdog fired before first command");
    pulse_len_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        wd_fire |=> pulse_q == PULSE_CYCLES ##1 pulse_q == PULSE_CYCLES - 1)
        else $error("host reset pulse length wrong");
    baud_map_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        setup_q[OFS_SPACE][7:4] == 4'h4 |=> uart_baud_div_q == BAUD4_DIV) else $error("baud divider wrong");
    load_end_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        setups_mode_q && host_valid && wr_idx_q == BLOCK_LAST |=> !setups_mode_q && block_loaded_q)
        else $error("block end not taken");
    // Reset edge excluded: the readout flops still hold zero there
    burst_en_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        !sys_rst && key_sel < NUM_KEYS |=> key_param_q.burst_en == (key_param_q.normal_detect_count != 4'h0))
        else $error("burst enable disagrees with count");
    quiet_bound_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        quiet_q < WDOG_CYCLES) else $error("watchdog count overran");
    // Pulse reaches the pin two cycles after the fire unless sleep holds it
    sequence s_wd_pulse;
        wd_fire ##1 !cond.sleep;
    endsequence
    wdog_pulse_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        s_wd_pulse |=> alert_out_q == $past(alert_fn[AL_POL])) else $error("host reset pulse missing");
endmodule // tsba_setup_alert

/* bench/tsba_host_model.sv */
/*
 Host controller model: sends command and setups bytes one strobe at a time.
 Assumes the testbench calls put_byte after reset has been released.
*/
`timescale 1ns/100ps
module tsba_host_model (
    // Clock
    input wire logic clk_sys,
    // Byte stream toward the device
    output logic host_valid,
    output logic [7:0] host_byte
);
    // ==========================================================
    // Idle line shows the inverse byte so stale data never looks valid
    initial begin
        host_valid = 1'b0;
        host_byte = 8'h00;
    end
    // One strobe per byte; low byte of 16-bit fields first
    task automatic put_byte(input logic [7:0] b);
        @(posedge clk_sys);
        host_valid <= 1'b1;
        host_byte <= b;
        @(posedge clk_sys);
        host_valid <= 1'b0;
        host_byte <= ~b;
    endtask
endmodule // tsba_host_model

/* bench/tsba_setup_alert_test.sv */
/*
 Self-checking bench for the setups store, reference check, alert pin and slots.
 Assumes shortened counts: SLOT_BASE 8, SLOT_STEP 4, watchdog 200, pulse 20.
*/
`timescale 1ns/100ps
module tsba_setup_alert_test import tsba_pkg::*;;
    logic clk_sys = 0, sys_rst = 1, cu = 0, cg = 0, rv = 0, bb = 0, hv, bs;
    logic [7:0] hb;
    logic [5:0] ks = 0, rk = 0, bk;
    logic [15:0] rl = 0, div;
    logic [47:0] low;
    tsba_cond_t cond = '0;
    tsba_key_t kp;
    tsba_glob_t g;
    logic sm, bl, al;
    int num_errors = 0, tests_run = 0;
    // ==========================================================
    always #2 clk_sys = ~clk_sys;
    tsba_host_model tsba_host_model_i (.clk_sys(clk_sys), .host_valid(hv), .host_byte(hb));
    tsba_setup_alert #(.WDOG_CYCLES(200), .PULSE_CYCLES(20), .SLOT_BASE(8), .SLOT_STEP(4)) tsba_setup_alert_i (
        .clk_sys(clk_sys), .sys_rst(sys_rst), .host_valid(hv), .host_byte(hb), .cmd_unknown(cu),
        .cmd_get_last(cg), .key_sel(ks), .key_param_q(kp), .glob_q(g), .setups_mode_q(sm),
        .block_loaded_q(bl), .uart_baud_div_q(div), .ref_valid(rv), .ref_key(rk), .ref_level(rl),
        .key_low_sig_q(low), .cond(cond), .alert_out_q(al), .burst_busy(bb),
        .burst_start_q(bs), .burst_key_q(bk));
    // ==========================================================
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic print_verdict();
        $display("errors %0d checks %0d", num_errors, tests_run);
        if (num_errors == 0 && tests_run > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    // Wait n edges, then settle 1ns past the last one before looking
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask
    // Defaults right after reset; alert idle high for active-low 0x6C
    task automatic t_defaults();
        int n = 0;
        tick(2);
        chk(g.alert_function, DEF_ALERT);
        chk(g.minimum_reference_level, 16'h0064);
        chk(div, 16'd26041);
        chk(g.burst_slot_time, 4'h0);
        chk(al, 1'b1);
        // First busy period fits a 12-cycle slot; a later one must not refit
        bb <= 1;
        tick(12);
        bb <= 0;
        tick(2);
        bb <= 1;
        tick(4);
        bb <= 0;
        repeat (48) begin
            tick(1);
            n += bs;
        end
        chk(n, 4);
        $display("defaults done");
    endtask
    // Broken command pair, then a full block with chosen fields
    task automatic t_load();
        tsba_host_model_i.put_byte(CMD_SETUPS);
        tsba_host_model_i.put_byte(8'h33);
        tick(1);
        chk(sm, 1'b0);
        tsba_host_model_i.put_byte(CMD_SETUPS);
        tsba_host_model_i.put_byte(CMD_SETUPS);
        tick(1);
        chk(sm, 1'b1);
        for (int i = 0; i < 247; i++)
            tsba_host_model_i.put_byte(i < 240 ? 8'h5A : i == 240 ? 8'h25 : i == 241 ? 8'h41 :
                i == 243 ? 8'h02 : i == 244 ? 8'h83 : 8'h00);
        ks <= 6'h05;
        tick(3);
        chk({sm, bl}, 2'b01);
        chk({kp.neg_threshold, kp.pos_threshold}, {5'd14, 5'd9});
        chk({kp.neg_drift_rate, kp.pos_drift_rate}, 8'h A5);
        chk({kp.burst_en, kp.normal_detect_count, kp.fast_detect_count}, 9'h1A5);
        chk(kp.neg_recal_delay, 8'h5A);
        chk({kp.scope_trigger_enable, kp.strongest_key_only, kp.burst_length_code, kp.pos_recal_delay},
            9'h0_5A);
        chk({g.release_margin, g.dwell_code, g.mains_lock_enable}, 7'b0101_10_0);
        chk({g.burst_slot_time, g.uart_baud_select, div}, {8'h14, 16'd2170});
        chk(g.minimum_reference_level, 16'h0200);
        $display("load done");
    endtask
    // Limit 512: one below flags, equal clears
    task automatic t_ref();
        rv <= 1;
        rk <= 6'h04;
        rl <= 16'h01FF;
        tick(1);
        rk <= 6'h03;
        tick(1);
        chk(low[4:3], 2'b11);
        rl <= 16'h0200;
        rk <= 6'h04;
        tick(1);
        rv <= 0;
        tick(1);
        chk(low[4:3], 2'b01);
        $display("ref done");
    endtask
    // Active-high comms error latch, cleared by get-last; slot every 8
    task automatic t_alert();
        int n = 0;
        cu <= 1;
        cg <= 1;
        tick(1);
        cu <= 0;
        cg <= 0;
        tick(2);
        chk(al, 1'b1);
        cg <= 1;
        cond.sleep <= 1;
        tick(1);
        cg <= 0;
        tick(2);
        chk(al, 1'b1);
        cond.sleep <= 0;
        tick(2);
        chk(al, 1'b0);
        repeat (80) begin
            tick(1);
            n += bs;
        end
        chk(n, 10);
        $display("alert and slots done");
    endtask
    // Host silent after the load: one 20-cycle reset pulse, two pin edges
    task automatic t_wdog();
        int n = 0, e = 0;
        logic p = 1'b0;
        repeat (250) begin
            tick(1);
            n += al;
            e += (al != p);
            p = al;
        end
        chk(n, 20);
        chk(e, 2);
        $display("watchdog done");
    endtask
    // ==========================================================
    initial begin
        #(4 * 8000);
        num_errors++;
        print_verdict();
    end
    initial begin
        repeat (3) @(posedge clk_sys);
        sys_rst <= 0;
        t_defaults();
        t_load();
        t_ref();
        t_alert();
        t_wdog();
        print_verdict();
    end
endmodule // tsba_setup_alert_test
